// ==== verilog/powerup_reset_preload_observe.sv ====
// top: power-up clear sequencer and test-mode control over a row of logic cells
// assumes a tester drives test_ctl and pins synchronous to ref_clk
// How it works
// RQ1 - power-up clears every flip-flop low, pin-routed or buried
// RQ2 - power-up clear finishes within ten microseconds
// RQ3 - pin level is cleared register value through programmed polarity
// RQ4 - outside system waits for setup times before first clock edge
// RQ5 - preload writes each flip-flop from its pin value
// RQ6 - observe forces every output buffer on, showing buried registers
// RQ7 - active async reset or preset overrides preloaded contents
// RQ8 - tester avoids preloading states that trigger async reset or preset
// RQ9 - combinatorial outputs become registered with zero terms while testing
// RQ10 - plain combinatorial outputs recover after testing ends
// RQ11 - tester restores combinatorial latches before checking them
// RQ12 - test control enters and leaves modes; normal runs after release
`timescale 1ns/1ps
`default_nettype none
module powerup_reset_preload_observe
  import test_ctl_pkg::*;
#(
  parameter int CELLS = NUM_CELLS,
  parameter int RESET_CYCLES = POWERUP_RESET_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire test_ctl_s test_ctl,
  input wire logic [CELLS-1:0] d_in,
  input wire logic [CELLS-1:0] comb_term,
  input wire logic [CELLS-1:0] async_rst,
  input wire logic [CELLS-1:0] async_set,
  input wire logic [CELLS-1:0] is_comb,
  input wire logic [CELLS-1:0] invert,
  input wire logic [CELLS-1:0] prog_oe,
  input wire logic [CELLS-1:0] pin_in,
  output logic [CELLS-1:0] pin_out,
  output logic [CELLS-1:0] pin_oe,
  output logic powerup_busy,
  output logic test_active
);
  localparam int CW = $clog2(RESET_CYCLES + 1);

  // refuse sizes the clear window cannot serve
  if (CELLS < 1 || RESET_CYCLES < 1 || RESET_CYCLES > POWERUP_RESET_CYCLES) begin : g_bad_params
    $error("unsupported parameter values");
  end

  logic [CW-1:0] count_reg;
  logic clear;
  logic observe_on;
  logic preload_we;
  logic [CELLS-1:0] q_unused;

  // count down the clear window after reset release
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count_reg <= CW'(RESET_CYCLES); // RQ2
      powerup_busy <= 1'b1;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - CW'(1);
      powerup_busy <= (count_reg != CW'(1));
    end else begin
      powerup_busy <= 1'b0;
    end
  end

  assign clear = reset || powerup_busy; // RQ1

  // test mode held only while the tester asserts enable
  always_ff @(posedge ref_clk) begin
    if (clear) begin
      test_active <= 1'b0;
    end else begin
      test_active <= test_ctl.enable && (test_ctl.mode != MODE_NORMAL); // RQ12
    end
  end

  assign preload_we = test_active && test_ctl.enable &&
                      (test_ctl.mode == MODE_PRELOAD) && test_ctl.load;
  assign observe_on = test_active && (test_ctl.mode == MODE_OBSERVE);

  genvar i;
  generate
    for (i = 0; i < CELLS; i++) begin : g_cell
      macro_cell u_cell (
        .ref_clk(ref_clk),
        .clear(clear),
        .d_in(d_in[i]),
        .async_rst(async_rst[i]),
        .async_set(async_set[i]),
        .comb_term(comb_term[i]),
        .is_comb(is_comb[i]),
        .invert(invert[i]),
        .prog_oe(prog_oe[i]),
        .test_active(test_active),
        .preload_we(preload_we),
        .observe(observe_on),
        .pin_in(pin_in[i]),
        .pin_out(pin_out[i]),
        .pin_oe(pin_oe[i]),
        .q(q_unused[i])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// ==== verilog/test_ctl_pkg.sv ====
// constants and carrier types for the power-up reset, preload and observe block
// assumes one 50 mhz clock and a synchronous active-high reset from supply ramp detection
package test_ctl_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int POWERUP_RESET_DURATION_US = 10;
  localparam int POWERUP_RESET_CYCLES =
    (POWERUP_RESET_DURATION_US * 1000) / CLK_PERIOD_NS;
  localparam int NUM_CELLS = 8;
  localparam logic POLARITY_RESET = 1'b0;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_PRELOAD = 2'b01,
    MODE_OBSERVE = 2'b10
  } test_mode_e;

  typedef struct packed {
    logic enable;
    logic load;
    test_mode_e mode;
  } test_ctl_s;
endpackage

// ==== verilog/macro_cell.sv ====
// one logic cell: register, polarity, combinatorial path and test overrides
// assumes cell logic terms come from outside, synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module macro_cell
  import test_ctl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic clear,
  input wire logic d_in,
  input wire logic async_rst,
  input wire logic async_set,
  input wire logic comb_term,
  input wire logic is_comb,
  input wire logic invert,
  input wire logic prog_oe,
  input wire logic test_active,
  input wire logic preload_we,
  input wire logic observe,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic q
);
  logic q_reg;
  logic q_next;
  logic level;

  always_comb begin
    q_next = q_reg;
    if (test_active) begin
      if (preload_we) begin
        q_next = pin_in; // RQ5
      end
    end else if (!is_comb) begin
      q_next = d_in;
    end
    if (async_rst) begin
      q_next = 1'b0; // RQ7
    end else if (async_set) begin
      q_next = 1'b1; // RQ7
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clear) begin
      q_reg <= 1'b0; // RQ1
    end else begin
      q_reg <= q_next;
    end
  end

  // combinatorial cells run registered with zero terms while testing
  always_comb begin
    if (is_comb && !test_active) begin
      level = comb_term; // RQ10
    end else begin
      level = q_reg; // RQ9
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clear) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_out <= level ^ invert; // RQ3
      pin_oe <= observe ? 1'b1 : (prog_oe && !test_active); // RQ6
    end
  end

  assign q = q_reg;
endmodule
`default_nettype wire

// ==== testbench/tester_pins.sv ====
// tester pin model: resolves each shared pin
// assumes the tester drive only counts while the cell is off
`timescale 1ns/1ps
`default_nettype none
module tester_pins (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] drive,
  output logic [7:0] pin_in
);
  assign pin_in = (pin_out & pin_oe) | (drive & ~pin_oe);
endmodule
`default_nettype wire

// ==== testbench/test_ctl_properties.sv ====
// checker for power-up clear and test modes
// assumes bind onto the top module
`timescale 1ns/1ps
`default_nettype none
module test_ctl_properties
  import test_ctl_pkg::*;
#(
  parameter int CELLS = 8,
  parameter int RESET_CYCLES = 4
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire test_ctl_s test_ctl,
  input wire logic [CELLS-1:0] async_rst,
  input wire logic [CELLS-1:0] async_set,
  input wire logic [CELLS-1:0] invert,
  input wire logic [CELLS-1:0] pin_in,
  input wire logic [CELLS-1:0] pin_out,
  input wire logic [CELLS-1:0] pin_oe,
  input wire logic powerup_busy,
  input wire logic test_active
);
  localparam int BUSY_MAX = RESET_CYCLES + 2;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_busy_clear: assert property (powerup_busy |-> !pin_out && !pin_oe && !test_active)
    else $error("outputs not clear during power-up");
  a_busy_bound: assert property ($fell(reset) |-> ##[1:BUSY_MAX] !powerup_busy)
    else $error("power-up clear too long");
  a_mode_entry: assert property (!powerup_busy && test_ctl.enable
    && test_ctl.mode != MODE_NORMAL |=> test_active)
    else $error("test mode not entered");
  a_mode_exit: assert property (!powerup_busy && !test_ctl.enable |=> !test_active)
    else $error("test mode not left");
  a_observe_oe: assert property (test_active && test_ctl.enable
    && test_ctl.mode == MODE_OBSERVE |=> pin_oe == '1)
    else $error("observe buffers off");
  a_preload_oe: assert property (test_active && test_ctl.enable
    && test_ctl.mode == MODE_PRELOAD |=> pin_oe == '0)
    else $error("pins driven in preload");
  a_preload_data: assert property (test_active && test_ctl.enable && test_ctl.load
    && test_ctl.mode == MODE_PRELOAD && !async_rst && !async_set
    |-> ##2 pin_out == ($past(pin_in, 2) ^ invert))
    else $error("preload value lost");
  a_async_wins: assert property (test_active && test_ctl.enable && async_rst != 0
    |-> ##2 ((pin_out ^ invert) & $past(async_rst, 2)) == 0)
    else $error("async reset ignored");
endmodule
bind powerup_reset_preload_observe test_ctl_properties #(.CELLS(CELLS),
  .RESET_CYCLES(RESET_CYCLES)) chk (.*);
`default_nettype wire

// ==== testbench/testbench.sv ====
// bench for power-up clear, preload and observe
// assumes the pin model closes each pin loop
`timescale 1ns/1ps
`default_nettype none
module testbench
  import test_ctl_pkg::*;
;
  logic ref_clk, reset, powerup_busy, test_active;
  test_ctl_s test_ctl;
  logic [7:0] d_in, comb_term, async_rst, async_set, is_comb, invert, prog_oe;
  logic [7:0] drv, pin_in, pin_out, pin_oe;
  int error_cnt, compares;
  powerup_reset_preload_observe #(.CELLS(8), .RESET_CYCLES(4)) DUT (.*);
  tester_pins pins (.pin_out(pin_out), .pin_oe(pin_oe), .drive(drv), .pin_in(pin_in));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task look(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task t_powerup;
    look(0);
    check(powerup_busy, 8'h01);
    check(pin_out | pin_oe, 8'h00);
    look(5);
    check(powerup_busy, 8'h00);
    look(2); // setup before first request
    $display("powerup done");
  endtask
  task t_preload;
    @(posedge ref_clk);
    test_ctl <= '{1'b1, 1'b0, MODE_PRELOAD};
    repeat (2) @(posedge ref_clk);
    test_ctl.load <= 1'b1;
    @(posedge ref_clk);
    test_ctl <= '{1'b1, 1'b0, MODE_OBSERVE};
    look(3);
    check(pin_oe, 8'hff);
    check(pin_out, 8'ha5 ^ 8'h3c);
    @(posedge ref_clk);
    async_rst <= 8'h01;
    async_set <= 8'h02;
    @(posedge ref_clk);
    {async_rst, async_set} <= '0;
    look(2);
    check(pin_out, 8'ha6 ^ 8'h3c);
    $display("preload done");
  endtask
  task t_comb;
    @(posedge ref_clk);
    is_comb <= 8'h0f;
    comb_term <= 8'hff; // plain comb outputs only
    look(2);
    check(pin_out, 8'ha6 ^ 8'h3c);
    @(posedge ref_clk);
    test_ctl <= '0;
    look(4);
    check(test_active, 8'h00);
    check(pin_oe, 8'h0f);
    check(pin_out, 8'h33);
    $display("comb done");
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (1000) @(posedge ref_clk);
    error_cnt++;
    results;
  end
  initial begin
    reset = 1'b1;
    test_ctl = '0;
    {d_in, comb_term, async_rst, async_set, is_comb} = '0;
    {invert, prog_oe, drv} = 24'h3c0fa5;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    t_powerup;
    t_preload;
    t_comb;
    results;
  end
endmodule
`default_nettype wire
